//--- verif/scwce_asserts.sv
`timescale 1ns/100ps
module scwce_asserts
    import scwce_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // task file
    input wire logic [2:0]  addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] wdata,
    input wire logic        byte_xfer,
    input wire logic [7:0]  rdata,
    input wire logic        intrq
);
    logic       look_reg;
    logic       first_reg;
    logic [7:0] st_reg;
    logic [8:0] words_reg;
    logic [2:0] bytes_reg;
    logic       op_wr;
    logic       dat_wr;
    logic       wr_op;
    assign op_wr  = wr && addr == TF_OPCODE;
    assign dat_wr = wr && addr == TF_DATA;
    assign wr_op  = op_wr && (wdata[7:0] == OP_WR_BUFFER ||
                    wdata[7:0] == OP_WR_LONG_A || wdata[7:0] == OP_WR_LONG_B ||
                    wdata[7:0] == OP_WR_GROUP || wdata[7:0] == OP_WR_GROUP_NE);
    // unit counts restart at each command and at each busy seen by the host
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            look_reg  <= 1'b0;
            first_reg <= 1'b0;
            st_reg    <= STATUS_READY;
            words_reg <= '0;
            bytes_reg <= '0;
        end else begin
            look_reg  <= rd && addr == TF_OPCODE;
            first_reg <= wr_op || (first_reg && !dat_wr);
            if (look_reg)
                st_reg <= rdata;
            if (op_wr || (look_reg && rdata[ST_BUSY]))
                {words_reg, bytes_reg} <= '0;
            else if (dat_wr && byte_xfer)
                bytes_reg <= bytes_reg + 3'h1;
            else if (dat_wr)
                words_reg <= words_reg + 9'h001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    busy_drq_excl_a: assert property (look_reg |->
        !(rdata[ST_BUSY] && rdata[ST_DRQ])) else $error("busy with drq");
    first_busy_a: assert property (look_reg && first_reg |->
        rdata[ST_BUSY] || rdata[ST_DRQ]) else $error("no busy after cmd");
    no_first_irq_a: assert property (first_reg |-> !$rose(intrq))
        else $error("irq before first data");
    data_on_drq_a: assert property (dat_wr |->
        st_reg[ST_DRQ] && !st_reg[ST_BUSY]) else $error("data without drq");
    cmd_when_idle_a: assert property (op_wr |->
        !st_reg[ST_BUSY] && !st_reg[ST_DRQ]) else $error("cmd while busy");
    byte_on_data_a: assert property (wr && byte_xfer |-> addr == TF_DATA)
        else $error("byte write off data port");
    bytes_after_words_a: assert property (dat_wr && byte_xfer |->
        words_reg == WORDS_PER_SECTOR) else $error("bytes before words");
    byte_limit_a: assert property (dat_wr && byte_xfer |->
        bytes_reg < 3'h4) else $error("too many check bytes");
    word_limit_a: assert property (dat_wr && !byte_xfer |->
        words_reg < WORDS_PER_SECTOR && bytes_reg == 3'h0)
        else $error("too many words");
    cover property (dat_wr && byte_xfer);
    cover property ($rose(intrq));
    cover property (look_reg && rdata[ST_ERR]);
endmodule : scwce_asserts

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import scwce_pkg::*;
;
    logic        clock, rst_b, cmd_valid, cmd_ready, cmd_linear, src_valid;
    logic        src_ready, done, done_error, refused, med_prog_req;
    logic        med_no_erase, med_use_host_check, med_done, med_fail;
    logic [7:0]  cmd_opcode, cmd_count, med_rd_addr;
    logic [27:0] cmd_lba, med_lba;
    logic [15:0] src_data, med_rd_data;
    logic [31:0] med_host_check, hc_seen;
    logic        take_seen, irq_q, got_err, got_ref, ne_seen, hc_use;
    logic [27:0] lba_seen[$];
    int          fail_count, num_checks, cnt, base, irqs, fail_at, slow;
    scwce_if scwce_if_i ();
    scwce_device scwce_device_i (.clock(clock), .rst_b(rst_b),
        .tf(scwce_if_i), .med_prog_req(med_prog_req), .med_lba(med_lba),
        .med_no_erase(med_no_erase), .med_use_host_check(med_use_host_check),
        .med_host_check(med_host_check), .med_done(med_done),
        .med_fail(med_fail), .med_rd_addr(med_rd_addr),
        .med_rd_data(med_rd_data));
    scwce_host scwce_host_i (.clock(clock), .rst_b(rst_b), .tf(scwce_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
        .cmd_lba(cmd_lba), .cmd_linear(cmd_linear), .cmd_count(cmd_count),
        .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
        .done(done), .done_error(done_error), .refused(refused));
    scwce_asserts scwce_asserts_i (.clock(clock), .rst_b(rst_b),
        .addr(scwce_if_i.addr), .wr(scwce_if_i.wr), .rd(scwce_if_i.rd),
        .wdata(scwce_if_i.wdata), .byte_xfer(scwce_if_i.byte_xfer),
        .rdata(scwce_if_i.rdata), .intrq(scwce_if_i.intrq));
    function automatic logic [15:0] word(input int i);
        return {~i[7:0], i[7:0]};
    endfunction : word
    task check(input string name, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task summarize;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task run(input logic [7:0] op, input logic [27:0] linear_address_select, input logic lin,
             input logic [7:0] cnt_in);
        @(negedge clock);
        {cmd_opcode, cmd_lba, cmd_linear, cmd_count} = {op, linear_address_select, lin, cnt_in};
        cmd_valid = 1'b1;
        irqs = 0;
        base = cnt;
        lba_seen.delete();
        while (cmd_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && refused !== 1'b1) @(negedge clock);
        got_err = done_error;
        got_ref = refused;
        repeat (4) @(negedge clock);
    endtask : run
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // source word follows the count of units the host has taken
    always @(negedge clock) begin
        if (take_seen)
            cnt = cnt + 1;
        src_data = word(cnt);
        take_seen = src_ready === 1'b1;
        if (scwce_if_i.intrq === 1'b1 && irq_q !== 1'b1)
            irqs++;
        irq_q = scwce_if_i.intrq;
    end
    // media: slow mode keeps busy long enough for several host polls
    initial begin
        forever begin
            @(negedge clock);
            if (med_prog_req === 1'b1) begin
                lba_seen.push_back(med_lba);
                {ne_seen, hc_use, hc_seen} =
                    {med_no_erase, med_use_host_check, med_host_check};
                repeat (slow ? 30 : 8) @(negedge clock);
                med_fail = lba_seen.size() == fail_at;
                med_done = 1'b1;
                @(negedge clock);
                {med_done, med_fail} = 2'b00;
            end
        end
    end
    // a sector costs about 800 cycles; the whole run stays far below this
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial begin
        logic [7:0] b;
        {rst_b, cmd_valid, cmd_linear, med_done, med_fail} = '0;
        {cmd_opcode, cmd_lba, cmd_count, med_rd_addr, src_data} = '0;
        {src_valid, take_seen, irq_q} = 3'b100;
        {fail_count, num_checks, cnt, fail_at, slow} = '0;
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
        run(OP_SET_BLOCK, '0, 1'b0, 8'h11);
        check("abort", got_err, 1);
        run(OP_WR_GROUP, '0, 1'b1, 8'h01);
        check("refuse", got_ref, 1);
        check("none", lba_seen.size(), 0);
        run(OP_SET_BLOCK, '0, 1'b0, 8'h02);
        run(OP_WR_GROUP, 28'h0ab_cdef, 1'b1, 8'h03);
        check("sectors", lba_seen.size(), 3);
        for (int i = 0; i < 3; i++) begin
            check("lba", lba_seen[i], 28'h0ab_cdef + i);
        end
        check("irq", irqs, 2);
        check("erase", ne_seen, 0);
        run(OP_SET_BLOCK, '0, 1'b0, 8'h01);
        slow = 1;
        run(OP_WR_GROUP_NE, 28'h000_0010, 1'b1, 8'h02);
        check("no_erase", ne_seen, 1);
        check("irq1", irqs, 2);
        {slow, fail_at} = {32'd0, 32'd2};
        run(OP_WR_GROUP, 28'h000_0100, 1'b1, 8'h00);
        check("fault", got_err, 1);
        check("stop", lba_seen.size(), 2);
        check("fail_lba", med_lba, 28'h000_0101);
        check("residual", scwce_device_i.state_reg.cnt, 8'hff);
        fail_at = 0;
        for (int k = 0; k < 2; k++) begin
            run(k ? OP_WR_LONG_B : OP_WR_LONG_A, 28'h123_4567, 1'b0, 8'h01);
            b = base[7:0];
            check("long_n", lba_seen.size(), 1);
            check("long_lba", lba_seen[0], 28'h123_4567);
            check("chk_use", hc_use, 1);
            check("chk", hc_seen, {b, b + 8'h01, b + 8'h02, b + 8'h03});
            check("long_ok", got_err, 0);
        end
        run(OP_WR_BUFFER, '0, 1'b0, 8'h01);
        check("buf_prog", lba_seen.size(), 0);
        for (int k = 0; k < 256; k += 255) begin
            @(negedge clock) med_rd_addr = k[7:0];
            @(negedge clock);
            check("buf", med_rd_data, word(base + k));
        end
        summarize();
    end
endmodule : tb_top

//--- verilog/scwce_device.sv
`timescale 1ns/100ps
// Functional notes
// - E8h reloads sector buffer, 512 bytes
// - 32h/33h long write moves 516 bytes
// - long write is always one sector
// - long write: 256 words, then 4 bytes
// - host check bytes kept or regenerated
// - grouped write sets busy within 400 ns
// - grouped write interrupts per block only
// - host checks data request per block; this host polls before every unit
// - host configures block size before grouped write
// - block size one always supported
// - total count, full blocks then remainder
// - grouped write without block size aborts
// - error ends command at failing sector
// - block interrupt coincides with data request
// - error leaves failing address, residual count
// - CDh is grouped write without erase
// - host should pre-erase before CDh
// - host should avoid long write
// - linear address from four task registers
// - busy, then data request, no first interrupt
// - count zero means 256 sectors
// - grouped mode disabled after reset
module scwce_device
    import scwce_pkg::*;
#(
    parameter bit KEEP_HOST_CHECK = 1'b1
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // task-file side
    scwce_if.device          tf,
    // media side
    output logic             med_prog_req,
    output logic [27:0]      med_lba,
    output logic             med_no_erase,
    output logic             med_use_host_check,
    output logic [31:0]      med_host_check,
    input  wire logic        med_done,
    input  wire logic        med_fail,
    input  wire logic [7:0]  med_rd_addr,
    output logic [15:0]      med_rd_data
);

    typedef struct packed {
        scwce_dstate_e st;
        logic [7:0]    feat;
        logic [7:0]    cnt;
        logic [7:0]    secn;
        logic [7:0]    cyll;
        logic [7:0]    cylh;
        logic [7:0]    dh;
        logic [7:0]    err;
        logic          intrq;
        logic          group_en;
        logic [4:0]    blk_size;
        logic [4:0]    blk_left;
        logic [8:0]    left;
        logic [8:0]    widx;
        logic          is_long;
        logic          is_group;
        logic          is_buf;
        logic          no_erase;
        logic [31:0]   check;
        logic [7:0]    rdata;
        logic          prog_req;
    } scwce_dev_s;

    scwce_dev_s  state_reg;
    scwce_dev_s  state_next;
    logic [15:0] buf_mem [0:255];
    logic [15:0] med_rd_data_reg;
    logic        data_wr;
    logic [8:0]  last_unit;
    logic [27:0] lba_next;

    function automatic logic [7:0] status_byte(scwce_dev_s s);
        logic [7:0] v;
        v = STATUS_READY;
        v[ST_BUSY] = (s.st == D_START) || (s.st == D_PROG);
        v[ST_DRQ]  = (s.st == D_XFER);
        v[ST_ERR]  = (s.err != 8'h00);
        return v;
    endfunction : status_byte

    assign data_wr   = tf.wr && (tf.addr == TF_DATA);
    assign last_unit = (state_reg.is_long ? LONG_UNITS : WORDS_PER_SECTOR)
                       - 9'h001;
    // linear mode counts through all 28 bits; otherwise only the sector
    // number steps, which suits single-track transfers
    assign lba_next  = state_reg.dh[LINEAR_SEL_BIT] ? med_lba + 28'h000_0001
                       : {med_lba[27:8], med_lba[7:0] + 8'h01};

    always_comb begin
        state_next = state_reg;
        state_next.prog_req = 1'b0;
        if (tf.rd) begin
            case (tf.addr)
                TF_FEAT:   state_next.rdata = state_reg.err;
                TF_COUNT:  state_next.rdata = state_reg.cnt;
                TF_SECNUM: state_next.rdata = state_reg.secn;
                TF_CYLLO:  state_next.rdata = state_reg.cyll;
                TF_CYLHI:  state_next.rdata = state_reg.cylh;
                TF_DRVHD:  state_next.rdata = state_reg.dh;
                TF_OPCODE: state_next.rdata = status_byte(state_reg);
                default:   state_next.rdata = 8'h00;
            endcase
            if (tf.addr == TF_OPCODE) begin
                state_next.intrq = 1'b0;
            end
        end
        case (state_reg.st)
            D_IDLE: begin
                if (tf.wr) begin
                    case (tf.addr)
                        TF_FEAT:   state_next.feat = tf.wdata[7:0];
                        TF_COUNT:  state_next.cnt  = tf.wdata[7:0];
                        TF_SECNUM: state_next.secn = tf.wdata[7:0];
                        TF_CYLLO:  state_next.cyll = tf.wdata[7:0];
                        TF_CYLHI:  state_next.cylh = tf.wdata[7:0];
                        TF_DRVHD:  state_next.dh   = tf.wdata[7:0];
                        default: ;
                    endcase
                end
                if (tf.wr && tf.addr == TF_OPCODE) begin
                    state_next.intrq    = 1'b0;
                    state_next.err      = 8'h00;
                    state_next.is_long  = 1'b0;
                    state_next.is_group = 1'b0;
                    state_next.is_buf   = 1'b0;
                    state_next.no_erase = 1'b0;
                    state_next.left     = 9'h001;
                    case (tf.wdata[7:0])
                        OP_WR_BUFFER: begin
                            state_next.is_buf = 1'b1;
                            state_next.st     = D_START;
                        end
                        OP_WR_LONG_A, OP_WR_LONG_B: begin
                            state_next.is_long = 1'b1;
                            state_next.st      = D_START;
                        end
                        OP_WR_GROUP, OP_WR_GROUP_NE: begin
                            if (!state_reg.group_en) begin
                                state_next.err   = ERR_ABORT;
                                state_next.intrq = 1'b1;
                            end else begin
                                state_next.is_group = 1'b1;
                                state_next.no_erase =
                                    (tf.wdata[7:0] == OP_WR_GROUP_NE);
                                state_next.left = (state_reg.cnt == 8'h00)
                                    ? FULL_COUNT
                                    : {1'b0, state_reg.cnt};
                                state_next.st = D_START;
                            end
                        end
                        OP_SET_BLOCK: begin
                            state_next.intrq = 1'b1;
                            if (state_reg.cnt == 8'h00) begin
                                state_next.group_en = 1'b0;
                            end else if (state_reg.cnt <= 8'(MAX_BLOCK)) begin
                                state_next.group_en = 1'b1;
                                state_next.blk_size = state_reg.cnt[4:0];
                            end else begin
                                state_next.group_en = 1'b0;
                                state_next.err      = ERR_ABORT;
                            end
                        end
                        default: begin
                            state_next.err   = ERR_ABORT;
                            state_next.intrq = 1'b1;
                        end
                    endcase
                end
            end
            D_START: begin
                // one busy cycle, then the data request with no interrupt
                state_next.st       = D_XFER;
                state_next.widx     = 9'h000;
                state_next.blk_left = state_reg.is_group ? state_reg.blk_size
                                      : ONE_BLOCK;
            end
            D_XFER: begin
                if (data_wr) begin
                    state_next.widx = state_reg.widx + 9'h001;
                    if (state_reg.widx >= WORDS_PER_SECTOR) begin
                        state_next.check = {state_reg.check[23:0],
                                            tf.wdata[7:0]};
                    end
                    if (state_reg.widx == last_unit) begin
                        if (state_reg.is_buf) begin
                            state_next.st    = D_IDLE;
                            state_next.intrq = 1'b1;
                        end else begin
                            state_next.st       = D_PROG;
                            state_next.prog_req = 1'b1;
                        end
                    end
                end
            end
            D_PROG: begin
                if (med_done && med_fail) begin
                    // address still names the failing sector
                    state_next.st    = D_IDLE;
                    state_next.err   = ERR_WRITE;
                    state_next.intrq = 1'b1;
                    state_next.cnt   = state_reg.left[7:0];
                end else if (med_done) begin
                    state_next.left = state_reg.left - 9'h001;
                    state_next.cnt  = 8'(state_reg.left - 9'h001);
                    {state_next.dh[3:0], state_next.cylh,
                     state_next.cyll, state_next.secn} = lba_next;
                    state_next.blk_left = state_reg.blk_left - 5'h01;
                    state_next.widx     = 9'h000;
                    if (state_reg.left == 9'h001) begin
                        state_next.st    = D_IDLE;
                        state_next.intrq = 1'b1;
                    end else begin
                        state_next.st = D_XFER;
                        if (state_reg.blk_left == ONE_BLOCK) begin
                            state_next.blk_left = state_reg.blk_size;
                            state_next.intrq    = 1'b1;
                        end
                    end
                end
            end
            default: state_next.st = D_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg          <= '0;
            state_reg.st       <= D_IDLE;
            state_reg.group_en <= 1'b0;
            state_reg.blk_size <= ONE_BLOCK;
        end else begin
            state_reg <= state_next;
        end
    end

    // the buffer has no reset; only written words are ever programmed
    always_ff @(posedge clock) begin
        if (state_reg.st == D_XFER && data_wr
            && state_reg.widx < WORDS_PER_SECTOR) begin
            buf_mem[state_reg.widx[7:0]] <= tf.wdata;
        end
        med_rd_data_reg <= buf_mem[med_rd_addr];
    end

    assign tf.rdata           = state_reg.rdata;
    assign tf.intrq           = state_reg.intrq;
    assign med_prog_req       = state_reg.prog_req;
    assign med_lba            = {state_reg.dh[3:0], state_reg.cylh,
                                 state_reg.cyll, state_reg.secn};
    assign med_no_erase       = state_reg.no_erase;
    assign med_use_host_check = state_reg.is_long && KEEP_HOST_CHECK;
    assign med_host_check     = state_reg.check;
    assign med_rd_data        = med_rd_data_reg;

endmodule : scwce_device

//--- verilog/scwce_host.sv
`timescale 1ns/100ps
module scwce_host
    import scwce_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // task-file side
    scwce_if.host            tf,
    // command side
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [27:0] cmd_lba,
    input  wire logic        cmd_linear,
    input  wire logic [7:0]  cmd_count,
    // data source
    input  wire logic        src_valid,
    output logic             src_ready,
    input  wire logic [15:0] src_data,
    // completion
    output logic             done,
    output logic             done_error,
    output logic             refused
);

    typedef struct packed {
        scwce_hstate_e st;
        logic [2:0]    idx;
        logic [7:0]    opcode;
        logic [27:0]   linear_address_select;
        logic          linear;
        logic [7:0]    count;
        logic [8:0]    widx;
        logic          blk_cfg;
        logic          done;
        logic          done_error;
        logic          refused;
    } scwce_host_s;

    scwce_host_s state_reg;
    scwce_host_s state_next;
    logic        is_long;
    logic [7:0]  setup_val;

    assign is_long = (state_reg.opcode == OP_WR_LONG_A)
                     || (state_reg.opcode == OP_WR_LONG_B);

    always_comb begin
        case (state_reg.idx)
            TF_COUNT:  setup_val = state_reg.count;
            TF_SECNUM: setup_val = state_reg.linear_address_select[7:0];
            TF_CYLLO:  setup_val = state_reg.linear_address_select[15:8];
            TF_CYLHI:  setup_val = state_reg.linear_address_select[23:16];
            TF_DRVHD:  setup_val = {1'b1, state_reg.linear, 2'b10,
                                    state_reg.linear_address_select[27:24]};
            default:   setup_val = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.refused = 1'b0;
        case (state_reg.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    if ((cmd_opcode == OP_WR_GROUP
                         || cmd_opcode == OP_WR_GROUP_NE)
                        && !state_reg.blk_cfg) begin
                        state_next.refused = 1'b1;
                    end else begin
                        state_next.st     = H_SETUP;
                        state_next.idx    = TF_COUNT;
                        state_next.opcode = cmd_opcode;
                        state_next.linear_address_select    = cmd_lba;
                        state_next.linear = cmd_linear;
                        state_next.widx   = 9'h000;
                        state_next.count  = (cmd_opcode == OP_WR_LONG_A
                            || cmd_opcode == OP_WR_LONG_B)
                            ? 8'h01 : cmd_count;
                    end
                end
            end
            H_SETUP: begin
                state_next.idx = state_reg.idx + 3'h1;
                if (state_reg.idx == TF_DRVHD) begin
                    state_next.st = H_CMD;
                end
            end
            H_CMD: begin
                state_next.st = H_POLL;
                if (state_reg.opcode == OP_SET_BLOCK) begin
                    state_next.blk_cfg = (state_reg.count != 8'h00);
                end
            end
            H_POLL: state_next.st = H_WAIT;
            H_WAIT: begin
                // polling every unit is slower than per block but never
                // writes into a busy device
                if (tf.rdata[ST_BUSY]) begin
                    state_next.st = H_POLL;
                end else if (tf.rdata[ST_DRQ]) begin
                    state_next.st = H_DATA;
                end else begin
                    state_next.st         = H_IDLE;
                    state_next.done       = 1'b1;
                    state_next.done_error = tf.rdata[ST_ERR];
                    if (state_reg.opcode == OP_SET_BLOCK
                        && tf.rdata[ST_ERR]) begin
                        state_next.blk_cfg = 1'b0;
                    end
                end
            end
            H_DATA: begin
                if (src_valid) begin
                    state_next.widx = (state_reg.widx == LONG_UNITS - 9'h001
                                       || (!is_long && state_reg.widx
                                       == WORDS_PER_SECTOR - 9'h001))
                                      ? 9'h000 : state_reg.widx + 9'h001;
                    state_next.st = H_POLL;
                end
            end
            default: state_next.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg    <= '0;
            state_reg.st <= H_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cmd_ready    = (state_reg.st == H_IDLE);
    assign src_ready    = (state_reg.st == H_DATA);
    assign tf.wr        = (state_reg.st == H_SETUP) || (state_reg.st == H_CMD)
                          || (state_reg.st == H_DATA && src_valid);
    assign tf.rd        = (state_reg.st == H_POLL);
    assign tf.addr      = (state_reg.st == H_SETUP) ? state_reg.idx
                          : (state_reg.st == H_DATA) ? TF_DATA : TF_OPCODE;
    assign tf.wdata     = (state_reg.st == H_DATA) ? src_data
                          : (state_reg.st == H_CMD) ? {8'h00, state_reg.opcode}
                          : {8'h00, setup_val};
    assign tf.byte_xfer = (state_reg.st == H_DATA) && is_long
                          && (state_reg.widx >= WORDS_PER_SECTOR);
    assign done         = state_reg.done;
    assign done_error   = state_reg.done_error;
    assign refused      = state_reg.refused;

endmodule : scwce_host

//--- verilog/scwce_if.sv
`timescale 1ns/100ps
interface scwce_if;
    logic [2:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic        byte_xfer;
    logic [7:0]  rdata;
    logic        intrq;

    modport device (
        input  addr,
        input  wr,
        input  rd,
        input  wdata,
        input  byte_xfer,
        output rdata,
        output intrq
    );

    modport host (
        output addr,
        output wr,
        output rd,
        output wdata,
        output byte_xfer,
        input  rdata,
        input  intrq
    );
endinterface : scwce_if

//--- verilog/scwce_pkg.sv
package scwce_pkg;
    // task-file offsets
    localparam logic [2:0] TF_DATA   = 3'h0;
    localparam logic [2:0] TF_FEAT   = 3'h1;
    localparam logic [2:0] TF_COUNT  = 3'h2;
    localparam logic [2:0] TF_SECNUM = 3'h3;
    localparam logic [2:0] TF_CYLLO  = 3'h4;
    localparam logic [2:0] TF_CYLHI  = 3'h5;
    localparam logic [2:0] TF_DRVHD  = 3'h6;
    localparam logic [2:0] TF_OPCODE = 3'h7;
    // opcodes
    localparam logic [7:0] OP_WR_BUFFER   = 8'hE8;
    localparam logic [7:0] OP_WR_LONG_A   = 8'h32;
    localparam logic [7:0] OP_WR_LONG_B   = 8'h33;
    localparam logic [7:0] OP_WR_GROUP    = 8'hC5;
    localparam logic [7:0] OP_WR_GROUP_NE = 8'hCD;
    localparam logic [7:0] OP_SET_BLOCK   = 8'hC6;
    // status and error bits
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_DRQ   = 3;
    localparam int ST_ERR   = 0;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_WRITE = 8'h40;
    localparam logic [7:0] STATUS_READY = 8'h40;
    localparam int LINEAR_SEL_BIT = 6;
    // transfer sizes: per-sector lengths in host units, then sector counts
    localparam logic [8:0] WORDS_PER_SECTOR = 9'h100;
    localparam logic [8:0] LONG_UNITS       = 9'h104;
    localparam logic [8:0] FULL_COUNT       = 9'h100;
    localparam logic [4:0] MAX_BLOCK        = 5'h10;
    localparam logic [4:0] ONE_BLOCK        = 5'h01;
    // busy must appear within this time of a grouped write
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUSY_MAX_NS   = 400;
    localparam int BUSY_MAX_CYC  = (BUSY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   BUSY_MAX_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        D_IDLE, D_START, D_XFER, D_PROG
    } scwce_dstate_e;

    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_CMD, H_POLL, H_WAIT, H_DATA
    } scwce_hstate_e;
endpackage : scwce_pkg
